/* include/hsfl_pkg.sv */
// What this block does
// - Host zero write clears a latched fault.
// - Switch-off edge of on pin or enable clears faults.
// - Undervoltage reset or regulator lockout clears faults.
// - Card insertion clears faults, sets card change.
// - A still present fault cannot be cleared.
// - Autoretry restart never clears fault bits.
// - Without autoretry, a set OV, UV or OC fault keeps switch off.
// - With autoretry, present flags hold switch off.
// - Three channels converted cyclically to 8-bit codes.
// - Source code full scale 102.4 V, 0.4 V step.
// - Aux code full scale 2.56 V, 10 mV step.
// - Sense code full scale 76.8 mV, 300 uV step.
// - Three result registers refreshed ten times per second.
// - Freeze bit stops updates, results become writable.
// - Two control bits select four GPIO functions.
// - GPIO defaults to release when power good.
// - Supply lockout only after filtered low time.
// - Fault and status bits 0-5 map causes.
// - Control bits 0-2 enable autoretry per fault.
// - Card low for settle delay captures on pin.
// - Address bits 4 to 2 select the register.
package hsfl_pkg;
	localparam logic [2:0] IDX_CONTROL = 3'h0;
	localparam logic [2:0] IDX_STATUS  = 3'h2;
	localparam logic [2:0] IDX_FAULT   = 3'h3;
	localparam logic [2:0] IDX_SRC     = 3'h4;
	localparam logic [2:0] IDX_AUX     = 3'h5;
	localparam logic [2:0] IDX_SENSE   = 3'h6;
	localparam logic [2:0] IDX_GPIO    = 3'h7;
	localparam logic [2:0] IDX_HOLE    = 3'h1;

	localparam int CTL_OV_AR   = 0;
	localparam int CTL_UV_AR   = 1;
	localparam int CTL_OC_AR   = 2;
	localparam int CTL_FET_EN  = 3;
	localparam int CTL_FREEZE  = 5;
	localparam int CTL_GPIO_LO = 6;
	localparam int CTL_GPIO_HI = 7;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] CTL_WMASK = 8'hEF;

	localparam int FLT_OV    = 0;
	localparam int FLT_UV    = 1;
	localparam int FLT_OC    = 2;
	localparam int FLT_PB    = 3;
	localparam int FLT_CARD  = 4;
	localparam int FLT_SHORT = 5;
	localparam logic [5:0] FLT_RESET     = 6'h00;
	localparam logic [5:0] FLT_ALL_MASK  = 6'h3F;
	localparam logic [5:0] FLT_CARD_KEEP = 6'h2F;

	// Result scaling in microvolts; the codes are passed through unchanged.
	localparam int SRC_FULL_UV   = 102400000;
	localparam int SRC_LSB_UV    = 400000;
	localparam int AUX_FULL_UV   = 2560000;
	localparam int AUX_LSB_UV    = 10000;
	localparam int SENSE_FULL_UV = 76800;
	localparam int SENSE_LSB_UV  = 300;

	localparam int CLK_HZ            = 50000000;
	localparam int CLK_PERIOD_NS     = 20;
	localparam int UVLO_FILTER_NS    = 5000;
	localparam int UVLO_FILTER_CYC   = (UVLO_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REG_FILTER_NS     = 1000;
	localparam int REG_FILTER_CYC    = (REG_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_MS         = 100;
	localparam int SETTLE_CYC_DEF    = SETTLE_MS * (CLK_HZ / 1000);
	localparam int REFRESH_HZ        = 10;
	localparam int FRAME_CYC_DEF     = CLK_HZ / REFRESH_HZ;
	localparam int LONG_W            = 23;

	typedef enum logic [1:0] {
		GPIO_REL_GOOD  = 2'h0,
		GPIO_PULL_GOOD = 2'h1,
		GPIO_OUTPUT    = 2'h2,
		GPIO_INPUT     = 2'h3
	} hsfl_gpio_mode_t;

	typedef enum logic [3:0] {
		ADC_IDLE  = 4'h1,
		ADC_SRC   = 4'h2,
		ADC_AUX   = 4'h4,
		ADC_SENSE = 4'h8
	} hsfl_adc_state_t;
endpackage

/* logic/hsfl_sync3.sv */
`timescale 1ns/100ps
module hsfl_sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// A bit only moves once the last two stages agree, so a bouncing edge counts once.
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q    <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q    <= (q & (s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q));
		end
	end
endmodule // hsfl_sync3

/* logic/hsfl_top.sv */
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
module hsfl_top
	import hsfl_pkg::*;
#(
	parameter int SETTLE_CYC = SETTLE_CYC_DEF,
	parameter int FRAME_CYC  = FRAME_CYC_DEF
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        on_request_pin,
	input  wire logic        card_presence_pin,
	input  wire logic        uv_reset_cmp,
	input  wire logic        internal_regulator_supply_low_cmp,
	input  wire logic        supply_low_cmp,
	input  wire logic        ov_present_in,
	input  wire logic        uv_present_in,
	input  wire logic        oc_present_in,
	input  wire logic        power_bad_in,
	input  wire logic        fet_short_in,
	output logic             adc_start,
	output logic      [1:0]  adc_channel,
	input  wire logic        adc_done,
	input  wire logic [7:0]  adc_code,
	output logic             switch_on,
	input  wire logic        gpio_in,
	output logic             gpio_out,
	output logic             gpio_oe_n
);
	logic [10:0]           pins_s;
	logic                  on_s;
	logic                  card_s;
	logic                  uv_reset_s;
	logic                  internal_regulator_supply_s;
	logic                  supply_s;
	logic [5:0]            present_hold;
	logic                  gpio_s;
	logic                  on_prev_q;
	logic                  card_prev_q;
	logic [7:0]            ctl_q;
	logic [7:0]            ctl_d;
	logic [5:0]            fault_q;
	logic [5:0]            fault_d;
	logic [7:0]            res_q [3];
	logic                  gpio_data_q;
	logic [7:0]            supply_cnt_q;
	logic [7:0]            internal_regulator_supply_cnt_q;
	logic [LONG_W-1:0]     settle_cnt_q;
	logic [LONG_W-1:0]     frame_cnt_q;
	hsfl_adc_state_t       adc_state_q;
	hsfl_adc_state_t       adc_state_d;
	logic [31:0]           prdata_q;

	hsfl_sync3 #(.W(11)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({gpio_in, fet_short_in, power_bad_in, oc_present_in, uv_present_in,
		       ov_present_in, supply_low_cmp, internal_regulator_supply_low_cmp, uv_reset_cmp,
		       card_presence_pin, on_request_pin}),
		.q   (pins_s)
	);

	assign on_s         = pins_s[0];
	assign card_s       = pins_s[1];
	assign uv_reset_s   = pins_s[2];
	assign internal_regulator_supply_s     = pins_s[3];
	assign supply_s     = pins_s[4];
	assign present_hold = {pins_s[9], 1'b0, pins_s[8:5]};
	assign gpio_s       = pins_s[10];

	// Register bus decode.
	wire [2:0]  idx       = paddr[4:2];
	wire        mapped    = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0) && (idx != IDX_HOLE);
	wire        access    = psel && penable;
	wire        wr_en     = access && pwrite && mapped;
	wire        ctl_wr    = wr_en && (idx == IDX_CONTROL);
	wire        fault_wr  = wr_en && (idx == IDX_FAULT);
	wire        freeze    = ctl_q[CTL_FREEZE];
	wire        res_wr    = wr_en && freeze && (idx >= IDX_SRC) && (idx <= IDX_SENSE);
	wire [1:0]  res_widx  = 2'(idx - IDX_SRC);
	wire        gpio_wr   = wr_en && (idx == IDX_GPIO);

	assign pready  = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata  = prdata_q;

	wire [5:0]  status_w  = {pins_s[9], ~card_s, pins_s[8:5]};
	wire [7:0]  rd_w      = (idx == IDX_CONTROL) ? ctl_q :
	                        (idx == IDX_STATUS)  ? {2'h0, status_w} :
	                        (idx == IDX_FAULT)   ? {2'h0, fault_q} :
	                        (idx == IDX_SRC)     ? res_q[0] :
	                        (idx == IDX_AUX)     ? res_q[1] :
	                        (idx == IDX_SENSE)   ? res_q[2] :
	                        (idx == IDX_GPIO)    ? {6'h00, gpio_s, gpio_data_q} : 8'h00;

	// Edges and filtered lockouts.
	wire        on_rise      = on_s && !on_prev_q;
	wire        on_fall      = !on_s && on_prev_q;
	wire        card_fall    = !card_s && card_prev_q;
	wire        card_edge    = card_s != card_prev_q;
	wire        supply_lock  = supply_cnt_q == 8'(UVLO_FILTER_CYC);
	wire        internal_regulator_supply_lock  = internal_regulator_supply_cnt_q == 8'(REG_FILTER_CYC);
	wire        settle_hit   = !card_s && (settle_cnt_q == LONG_W'(SETTLE_CYC - 1));
	wire        frame_tick   = frame_cnt_q == LONG_W'(FRAME_CYC - 1);

	// Control register; the on pin and card settle move the enable bit.
	wire [7:0]  ctl_base     = ctl_wr ? (pwdata[7:0] & CTL_WMASK) : ctl_q;
	wire        fet_next     = settle_hit ? on_s :
	                           on_rise    ? 1'b1 :
	                           on_fall    ? 1'b0 : ctl_base[CTL_FET_EN];
	wire        fet_fall     = ctl_q[CTL_FET_EN] && !fet_next;
	assign ctl_d = {ctl_base[7:4], fet_next, ctl_base[2:0]};

	// Fault register; a set in the same cycle as a clear wins.
	wire        clr_all      = fet_fall || on_fall || uv_reset_s || internal_regulator_supply_lock;
	wire [5:0]  clr_hw       = (clr_all ? FLT_ALL_MASK : 6'h00) |
	                           (card_fall ? FLT_CARD_KEEP : 6'h00);
	wire [5:0]  clr_sw       = fault_wr ? ~pwdata[5:0] : 6'h00;
	wire [5:0]  clr_eff      = (clr_hw | clr_sw) & ~present_hold;
	wire [5:0]  fault_set    = {pins_s[9], card_edge, pins_s[8] & switch_on, pins_s[7:5]};
	assign fault_d = (fault_q & ~clr_eff) | fault_set;

	// Restart hold; autoretry restarts touch no fault bit.
	wire [2:0]  hold_type;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_hold
			assign hold_type[gi] = ctl_q[gi] ? pins_s[5+gi] : fault_q[gi];
		end
	endgenerate
	wire        switch_d = ctl_q[CTL_FET_EN] && !card_s && !supply_lock && !internal_regulator_supply_lock &&
	                       !uv_reset_s && !(|hold_type);

	// GPIO function select; power good means the power bad condition is low.
	wire [1:0]  gpio_mode = ctl_q[CTL_GPIO_HI:CTL_GPIO_LO];
	wire        gpio_pull = (gpio_mode == GPIO_REL_GOOD)  ? pins_s[8] :
	                        (gpio_mode == GPIO_PULL_GOOD) ? !pins_s[8] :
	                        (gpio_mode == GPIO_OUTPUT)    ? !gpio_data_q : 1'b0;
	assign gpio_out = 1'b0;

	// Converter sequencer: one sweep of the three channels per refresh frame.
	always_comb begin
		adc_state_d = adc_state_q;
		case (adc_state_q)
			ADC_IDLE:  if (frame_tick) adc_state_d = ADC_SRC;
			ADC_SRC:   if (adc_done) adc_state_d = ADC_AUX;
			ADC_AUX:   if (adc_done) adc_state_d = ADC_SENSE;
			ADC_SENSE: if (adc_done) adc_state_d = ADC_IDLE;
			default:   adc_state_d = ADC_IDLE;
		endcase
	end
	wire        adc_launch = (adc_state_d != adc_state_q) && (adc_state_d != ADC_IDLE);
	wire [1:0]  adc_ch_d   = (adc_state_d == ADC_AUX)   ? 2'h1 :
	                         (adc_state_d == ADC_SENSE) ? 2'h2 : 2'h0;
	wire        adc_store  = adc_done && (adc_state_q != ADC_IDLE) && !freeze;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_q       <= CTL_RESET;
			fault_q     <= FLT_RESET;
			on_prev_q   <= 1'b0;
			card_prev_q <= 1'b0;
			switch_on   <= 1'b0;
			gpio_oe_n   <= 1'b1;
			gpio_data_q <= 1'b0;
			prdata_q    <= 32'h00000000;
		end else begin
			ctl_q       <= ctl_d;
			fault_q     <= fault_d;
			on_prev_q   <= on_s;
			card_prev_q <= card_s;
			switch_on   <= switch_d;
			gpio_oe_n   <= !gpio_pull;
			gpio_data_q <= gpio_wr ? pwdata[0] : gpio_data_q;
			prdata_q    <= (psel && !penable) ? {24'h000000, rd_w} : prdata_q;
		end
	end

	// The results hold their value on a clear; the next frame overwrites them.
	always_ff @(posedge clk) begin
		if (rst) begin
			res_q[0] <= 8'h00;
			res_q[1] <= 8'h00;
			res_q[2] <= 8'h00;
		end else if (adc_store) begin
			res_q[adc_channel] <= adc_code;
		end else if (res_wr) begin
			res_q[res_widx] <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			adc_state_q <= ADC_IDLE;
			adc_start   <= 1'b0;
			adc_channel <= 2'h0;
			frame_cnt_q <= '0;
		end else begin
			adc_state_q <= adc_state_d;
			adc_start   <= adc_launch;
			adc_channel <= adc_launch ? adc_ch_d : adc_channel;
			frame_cnt_q <= frame_tick ? '0 : frame_cnt_q + LONG_W'(1);
		end
	end

	// Filters: brief supply dips must not lock the switch out.
	always_ff @(posedge clk) begin
		if (rst) begin
			supply_cnt_q <= 8'h00;
			internal_regulator_supply_cnt_q <= 8'h00;
			settle_cnt_q <= '0;
		end else begin
			supply_cnt_q <= !supply_s ? 8'h00 : supply_lock ? supply_cnt_q : supply_cnt_q + 8'h01;
			internal_regulator_supply_cnt_q <= !internal_regulator_supply_s ? 8'h00 : internal_regulator_supply_lock ? internal_regulator_supply_cnt_q : internal_regulator_supply_cnt_q + 8'h01;
			settle_cnt_q <= card_s ? '0 :
			                (settle_cnt_q == LONG_W'(SETTLE_CYC)) ? settle_cnt_q :
			                settle_cnt_q + LONG_W'(1);
		end
	end

	sw_clear_a: assert property (@(posedge clk) disable iff (rst)
		(fault_wr && !pwdata[FLT_OV] && !pins_s[5]) |=> !fault_q[FLT_OV])
		else $error("Overvoltage fault not cleared by zero write.");

	keep_one_a: assert property (@(posedge clk) disable iff (rst)
		(fault_wr && pwdata[FLT_UV] && !clr_hw[FLT_UV]) |=>
		(fault_q[FLT_UV] == $past(fault_q[FLT_UV])) || $past(pins_s[6]))
		else $error("Fault bit written one changed value.");

	off_clear_a: assert property (@(posedge clk) disable iff (rst)
		(fet_fall && !(|status_w[3:0]) && !pins_s[9]) |=> (fault_q & FLT_CARD_KEEP) == 6'h00)
		else $error("Switch-off edge left a fault bit set.");

	lock_clear_a: assert property (@(posedge clk) disable iff (rst)
		(uv_reset_s && pins_s[9:5] == 5'h00 && !card_edge) |=> fault_q == 6'h00)
		else $error("Undervoltage reset left faults set.");

	card_in_a: assert property (@(posedge clk) disable iff (rst)
		card_fall |=> fault_q[FLT_CARD] && (fault_q[FLT_OC] == $past(pins_s[7])))
		else $error("Card insertion did not clear faults and flag change.");

	present_hold_a: assert property (@(posedge clk) disable iff (rst)
		pins_s[7] |=> fault_q[FLT_OC] [*1] ##1 (fault_q[FLT_OC] || !$past(pins_s[7])))
		else $error("Present overcurrent fault was cleared.");

	fault_off_a: assert property (@(posedge clk) disable iff (rst)
		(!ctl_q[CTL_OC_AR] && fault_q[FLT_OC]) |=> !switch_on)
		else $error("Switch on while overcurrent fault latched.");

	retry_hold_a: assert property (@(posedge clk) disable iff (rst)
		(ctl_q[CTL_OV_AR] && pins_s[5]) |=> !switch_on)
		else $error("Switch on while overvoltage present under autoretry.");

	retry_keep_a: assert property (@(posedge clk) disable iff (rst)
		(ctl_q[CTL_UV_AR] && fault_q[FLT_UV] && !clr_all && !card_fall && !fault_wr) |=> fault_q[FLT_UV])
		else $error("Autoretry cleared a fault bit.");

	result_load_a: assert property (@(posedge clk) disable iff (rst)
		(adc_store && adc_channel == 2'h2) |=> res_q[2] == $past(adc_code))
		else $error("Sense result not stored.");

	freeze_hold_a: assert property (@(posedge clk) disable iff (rst)
		(freeze && !res_wr) |=> $stable(res_q[0]) && $stable(res_q[1]) && $stable(res_q[2]))
		else $error("Result changed while frozen.");

	gpio_rst_a: assert property (@(posedge clk)
		rst |=> ctl_q[CTL_GPIO_HI:CTL_GPIO_LO] == GPIO_REL_GOOD)
		else $error("GPIO select not at default after reset.");

	uvlo_filt_a: assert property (@(posedge clk) disable iff (rst)
		$rose(supply_lock) |-> $past(supply_s, 2) && $past(supply_s, 1))
		else $error("Supply lockout without filtered low time.");

	settle_cap_a: assert property (@(posedge clk) disable iff (rst)
		settle_hit |=> ctl_q[CTL_FET_EN] == $past(on_s))
		else $error("On pin not captured after card settle.");

	gpio_sel_a: assert property (@(posedge clk) disable iff (rst)
		(gpio_mode == GPIO_INPUT) |=> gpio_oe_n || $past(gpio_mode) != GPIO_INPUT)
		else $error("GPIO driven while configured as input.");

	res_write_a: assert property (@(posedge clk) disable iff (rst)
		(res_wr && idx == IDX_SRC) |=> res_q[0] == $past(pwdata[7:0]))
		else $error("Source result not written while frozen.");

	card_flag_a: assert property (@(posedge clk) disable iff (rst)
		card_edge |=> fault_q[FLT_CARD])
		else $error("Card pin edge did not flag a change.");

	lock_off_a: assert property (@(posedge clk) disable iff (rst)
		supply_lock |=> !switch_on)
		else $error("Switch on during supply lockout.");

	gpio_rel_a: assert property (@(posedge clk) disable iff (rst)
		(gpio_mode == GPIO_REL_GOOD && !pins_s[8]) |=> gpio_oe_n)
		else $error("GPIO pulled low while power good.");
endmodule // hsfl_top

/* verification/hsfl_adc_model.sv */
`timescale 1ns/100ps
module hsfl_adc_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       adc_start,
	input  wire logic [1:0] adc_channel,
	input  wire logic [7:0] code_base,
	output logic            adc_done,
	output logic      [7:0] adc_code
);
	logic [2:0] wait_q;
	logic       busy_q;
	logic [1:0] ch_q;
	// Later channels answer more slowly, so both prompt and slow replies occur.
	always_ff @(posedge clk) begin
		adc_done <= 1'b0;
		adc_code <= ~adc_code;
		if (rst) begin
			busy_q   <= 1'b0;
			adc_code <= 8'h00;
		end else if (adc_start) begin
			busy_q <= 1'b1;
			ch_q   <= adc_channel;
			wait_q <= {adc_channel, 1'b1};
		end else if (busy_q && wait_q == 3'h0) begin
			busy_q   <= 1'b0;
			adc_done <= 1'b1;
			adc_code <= code_base + {6'h00, ch_q};
		end else if (busy_q) begin
			wait_q <= wait_q - 3'h1;
		end
	end
endmodule // hsfl_adc_model

/* verification/hot_swap_fault_latch_and_monitor_test.sv */
`timescale 1ns/100ps
module hot_swap_fault_latch_and_monitor_test
	import hsfl_pkg::*;
;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00, base = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, on_pin = 0, card = 0, uvr = 0, ivl = 0, sup = 0;
	logic [2:0] pres = 3'h0;
	logic pb = 0, short = 0, adc_start, adc_done, switch_on, gin = 0, gpio_oe_n, gout;
	logic [1:0] adc_channel;
	logic [7:0] adc_code;
	int seed, fails = 0, compares = 0, cyc = 0;
	always #10 clk = ~clk;
	hsfl_top #(.SETTLE_CYC(20), .FRAME_CYC(64)) DUT (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .on_request_pin(on_pin), .card_presence_pin(card),
		.uv_reset_cmp(uvr), .internal_regulator_supply_low_cmp(ivl), .supply_low_cmp(sup),
		.ov_present_in(pres[0]), .uv_present_in(pres[1]), .oc_present_in(pres[2]),
		.power_bad_in(pb), .fet_short_in(short), .adc_start(adc_start),
		.adc_channel(adc_channel), .adc_done(adc_done), .adc_code(adc_code),
		.switch_on(switch_on), .gpio_in(gin), .gpio_out(gout), .gpio_oe_n(gpio_oe_n));
	hsfl_adc_model adc (.clk(clk), .rst(rst), .adc_start(adc_start), .adc_channel(adc_channel),
		.code_base(base), .adc_done(adc_done), .adc_code(adc_code));
	task automatic final_report;
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [2:0] idx, input logic [7:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {3'h0, idx, 2'h0};
		pwdata  <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [2:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		check(r, {24'h000000, exp});
	endtask
	task automatic shortpulse;
		short <= 1'b1;
		tick(8);
		short <= 1'b0;
		tick(8);
	endtask
	// Open-drain level expected for each GPIO mode; low output enable pulls the pin low.
	function automatic logic gx(input logic [1:0] m, input logic bad, input logic dat);
		case (m)
			2'h0: return ~bad;
			2'h1: return bad;
			2'h2: return dat;
			default: return 1'b1;
		endcase
	endfunction
	initial begin
		seed = 95965;
		tick(20);
		rst <= 1'b0;
		tick(30);
		rchk(IDX_CONTROL, CTL_RESET);
		check(gpio_oe_n, 1'b1);
		rchk(IDX_FAULT, 8'h00);
		apb(1'b0, IDX_HOLE, 8'h00);
		check(e, 1'b1);
		apb(1'b1, IDX_CONTROL, 8'h08);
		tick(4);
		check(switch_on, 1'b1);
		for (int k = 0; k < 3; k++) begin
			pres[k] <= 1'b1;
			tick(8);
			check(switch_on, 1'b0);
			rchk(IDX_STATUS, 8'h10 | (8'h01 << k));
			apb(1'b1, IDX_FAULT, 8'h00);
			rchk(IDX_FAULT, 8'h01 << k);
			pres[k] <= 1'b0;
			tick(8);
			check(switch_on, 1'b0);
			apb(1'b1, IDX_FAULT, 8'h3F);
			rchk(IDX_FAULT, 8'h01 << k);
			apb(1'b1, IDX_FAULT, 8'hFF ^ (8'h01 << k));
			tick(4);
			check(switch_on, 1'b1);
			rchk(IDX_FAULT, 8'h00);
		end
		apb(1'b1, IDX_CONTROL, 8'h0F);
		for (int k = 0; k < 3; k++) begin
			pres[k] <= 1'b1;
			tick(8);
			check(switch_on, 1'b0);
			pres[k] <= 1'b0;
			tick(8);
			check(switch_on, 1'b1);
		end
		rchk(IDX_FAULT, 8'h07);
		apb(1'b1, IDX_CONTROL, 8'h07);
		rchk(IDX_FAULT, 8'h00);
		apb(1'b1, IDX_CONTROL, 8'h08);
		sup <= 1'b1;
		tick(200);
		check(switch_on, 1'b1);
		tick(80);
		check(switch_on, 1'b0);
		sup <= 1'b0;
		shortpulse();
		rchk(IDX_FAULT, 8'h20);
		uvr <= 1'b1;
		tick(8);
		uvr <= 1'b0;
		rchk(IDX_FAULT, 8'h00);
		shortpulse();
		ivl <= 1'b1;
		tick(60);
		ivl <= 1'b0;
		rchk(IDX_FAULT, 8'h00);
		on_pin <= 1'b1;
		tick(8);
		shortpulse();
		on_pin <= 1'b0;
		tick(8);
		rchk(IDX_FAULT, 8'h00);
		shortpulse();
		card <= 1'b1;
		tick(8);
		card <= 1'b0;
		tick(8);
		rchk(IDX_FAULT, 8'h10);
		apb(1'b1, IDX_CONTROL, 8'h08);
		tick(30);
		rchk(IDX_CONTROL, 8'h00);
		base <= 8'($random(seed));
		tick(200);
		for (int c = 0; c < 3; c++)
			rchk(IDX_SRC + c[2:0], base + c[7:0]);
		apb(1'b1, IDX_CONTROL, 8'h20);
		apb(1'b1, IDX_SRC, 8'hA5);
		base <= base + 8'h40;
		tick(200);
		rchk(IDX_SRC, 8'hA5);
		rchk(IDX_AUX, base - 8'h3F);
		apb(1'b1, IDX_CONTROL, 8'h00);
		tick(200);
		rchk(IDX_SRC, base);
		for (int m = 0; m < 8; m++) begin
			pb  <= $random(seed);
			gin <= $random(seed);
			apb(1'b1, IDX_GPIO, {7'h00, m[2]});
			apb(1'b1, IDX_CONTROL, {m[1:0], 6'h00});
			tick(8);
			check(gpio_oe_n, gx(m[1:0], pb, m[2]));
			check(gout, 1'b0);
			rchk(IDX_GPIO, {6'h00, gin, m[2]});
		end
		final_report();
	end
endmodule // hot_swap_fault_latch_and_monitor_test
